// >>> logic/pccfg_pkg.sv
// Package: register map, field layout and timing constants of the card configuration block
package pccfg_pkg;

  // Register index; each register is one aligned word, so its byte address is four times it
  localparam logic [7:0] IDX_IFC4 = 8'h2C;
  localparam logic [7:0] IDX_CMP_IO = 8'h2D;
  localparam logic [7:0] IDX_CMP_MEM = 8'h2E;
  localparam logic [7:0] IDX_MODE = 8'h30;
  localparam logic [7:0] IDX_PM_COUNT = 8'h31;
  localparam logic [7:0] IDX_STATUS = 8'h32;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h33;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h34;
  localparam logic [7:0] IDX_CTRL = 8'h35;
  localparam logic [9:0] ADDR_IFC4 = {IDX_IFC4, 2'b00};
  localparam logic [9:0] ADDR_CMP_IO = {IDX_CMP_IO, 2'b00};
  localparam logic [9:0] ADDR_CMP_MEM = {IDX_CMP_MEM, 2'b00};
  localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [9:0] ADDR_PM_COUNT = {IDX_PM_COUNT, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};

  localparam logic [7:0] RST_IFC4 = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_PM_COUNT = 8'h01;

  localparam int IFC4_POLL_BIT = 3;
  localparam int IFC4_GIE_BIT = 4;
  localparam int IFC4_HEV_BIT = 5;
  localparam int IFC4_BVD_BIT = 6;
  localparam int IFC4_ABUSY_BIT = 7;
  localparam int CMP_LO_EN_BIT = 3;
  localparam int CMP_HI_EN_BIT = 7;

  // Own mode register: bit 0 memory, bit 1 independent, bit 6 I/O, bits 11..8 pri/sec
  localparam int MODE_MEM_BIT = 0;
  localparam int MODE_INDP_BIT = 1;
  localparam int MODE_IO_BIT = 6;
  localparam int MODE_PS_LSB = 8;

  // Interrupt status bit positions
  localparam int EV_HOST_IO = 0;
  localparam int EV_ABUSY_DONE = 1;
  localparam int EV_PM_EXPIRE = 2;

  localparam int CLK_HZ = 10_000_000;
  localparam int ABUSY_CYCLES = 32768;
  localparam int PM_BLOCK_POW = 27;
  // Tick periods in ns at 20 MHz reference: 6400, 12800, 100; scaled to our clock
  localparam int TICK_6P4_NS = 6400;
  localparam int TICK_12P8_NS = 12800;
  localparam int TICK_100_NS = 100;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int TICK_6P4_CYC = (TICK_6P4_NS * (CLK_HZ / 1000)) / (NS_PER_S / 1000);
  localparam int TICK_12P8_CYC = (TICK_12P8_NS * (CLK_HZ / 1000)) / (NS_PER_S / 1000);
  localparam int TICK_100_CYC = (TICK_100_NS * (CLK_HZ / 1000)) / (NS_PER_S / 1000);

  typedef enum logic [2:0] {
    PM_SCALE_OFF0 = 3'b000,
    PM_SCALE_A = 3'b001,
    PM_SCALE_STOP = 3'b010,
    PM_SCALE_B = 3'b011,
    PM_SCALE_FAST = 3'b100,
    PM_SCALE_C = 3'b101,
    PM_SCALE_D = 3'b110,
    PM_SCALE_E = 3'b111
  } pccfg_scale_t;

  typedef struct packed {
    logic cfg_wr;
    logic [5:0] cfg_index;
    logic io_event_wr;
    logic bus_activity;
    logic reset_req;
    logic ata_io_mode;
    logic ata_mem_mode;
  } pccfg_host_t;

  typedef struct packed {
    logic io_mode_en;
    logic mem_mode_en;
    logic indp_mode_en;
    logic [3:0] pri_sec_en;
  } pccfg_modes_t;

endpackage

// >>> logic/pccfg_top.sv
// Top: configuration, compare, auto-poll, auto-busy and power-timer logic behind APB
`timescale 1ns/1ps
module pccfg_top #(
  parameter int ABUSY_LEN = pccfg_pkg::ABUSY_CYCLES,
  parameter int PM_BLOCK = 1 << pccfg_pkg::PM_BLOCK_POW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pccfg_pkg::pccfg_host_t host,
  input wire logic drive_busy_raw,
  input wire logic [1:0] battery_voltage_detect,
  input wire logic local_irq_src,
  input wire logic local_busy_clear,
  output pccfg_pkg::pccfg_modes_t modes,
  output logic host_ready_busy,
  output logic [7:0] pin_repl,
  output logic [1:0] bvd_out,
  output logic local_cpu_irq_pin,
  output logic pm_power_down,
  output logic irq
);
  import pccfg_pkg::*;

  function automatic logic idx_hit(input logic en, input logic [2:0] val, input logic [2:0] wr);
    idx_hit = en && (val == wr);
  endfunction

  logic [7:0] ifc4_q;
  logic [7:0] cmp_io_q;
  logic [7:0] cmp_mem_q;
  logic [11:0] mode_q;
  logic [7:0] pm_count_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [2:0] sel_index_q;
  logic index_written_q;
  logic host_ev_q;
  logic abusy_q;
  logic [15:0] abusy_cnt_q;
  logic [2:0] bsy_sync_q;
  logic busy_q;
  logic [2:0] bvd0_sync_q;
  logic [2:0] bvd1_sync_q;
  logic [1:0] bvd_q;
  logic [2:0] lirq_sync_q;
  logic lirq_q;
  logic [15:0] tick_cnt_q;
  logic [35:0] pm_cnt_q;
  logic pm_down_q;
  logic [31:0] prdata_q;

  logic wr_en;
  logic rd_en;
  logic [9:0] reg_addr;
  logic [2:0] ev;
  logic tick;
  logic [15:0] tick_len;
  logic [35:0] pm_limit;

  assign reg_addr = paddr[9:0];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_q;

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifc4_q <= RST_IFC4;
      cmp_io_q <= RST_CMP;
      cmp_mem_q <= RST_CMP;
      mode_q <= 12'h000;
      pm_count_q <= RST_PM_COUNT;
      irq_mask_q <= 3'h0;
    end else if (wr_en && pstrb[0]) begin
      unique case (reg_addr)
        ADDR_IFC4: ifc4_q <= pwdata[7:0];
        ADDR_CMP_IO: cmp_io_q <= pwdata[7:0];
        ADDR_CMP_MEM: cmp_mem_q <= pwdata[7:0];
        ADDR_MODE: mode_q <= pwdata[11:0];
        ADDR_PM_COUNT: pm_count_q <= pwdata[7:0];
        ADDR_IRQ_MASK: irq_mask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Latch the index written by the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_index_q <= 3'h0;
      index_written_q <= 1'b0;
    end else if (host.cfg_wr) begin
      sel_index_q <= host.cfg_index[2:0];
      index_written_q <= 1'b1;
    end
  end

  // Mode enables gated by compare match once an index has been written
  always_comb begin
    modes.io_mode_en = mode_q[MODE_IO_BIT] && index_written_q
      && (!cmp_io_q[CMP_HI_EN_BIT] || idx_hit(1'b1, cmp_io_q[6:4], sel_index_q));
    modes.pri_sec_en[3:2] = mode_q[MODE_PS_LSB+3 -: 2] & {2{index_written_q
      && (!cmp_io_q[CMP_HI_EN_BIT] || idx_hit(1'b1, cmp_io_q[6:4], sel_index_q))}};
    modes.pri_sec_en[1:0] = mode_q[MODE_PS_LSB+1 -: 2] & {2{index_written_q
      && (!cmp_io_q[CMP_LO_EN_BIT] || idx_hit(1'b1, cmp_io_q[2:0], sel_index_q))}};
    modes.mem_mode_en = mode_q[MODE_MEM_BIT] && index_written_q
      && (!cmp_mem_q[CMP_LO_EN_BIT] || idx_hit(1'b1, cmp_mem_q[2:0], sel_index_q));
    modes.indp_mode_en = mode_q[MODE_INDP_BIT] && index_written_q
      && (!cmp_mem_q[CMP_HI_EN_BIT] || idx_hit(1'b1, cmp_mem_q[6:4], sel_index_q));
  end

  // Pin synchronisers, three stages, change accepted when stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsy_sync_q <= 3'h0;
      bvd0_sync_q <= 3'h0;
      bvd1_sync_q <= 3'h0;
      lirq_sync_q <= 3'h0;
      busy_q <= 1'b0;
      bvd_q <= 2'h0;
      lirq_q <= 1'b0;
    end else begin
      bsy_sync_q <= {bsy_sync_q[1:0], drive_busy_raw};
      bvd0_sync_q <= {bvd0_sync_q[1:0], battery_voltage_detect[0]};
      bvd1_sync_q <= {bvd1_sync_q[1:0], battery_voltage_detect[1]};
      lirq_sync_q <= {lirq_sync_q[1:0], local_irq_src};
      if (bsy_sync_q[1] == bsy_sync_q[2]) begin
        busy_q <= bsy_sync_q[2];
      end
      if (bvd0_sync_q[1] == bvd0_sync_q[2]) begin
        bvd_q[0] <= bvd0_sync_q[2];
      end
      if (bvd1_sync_q[1] == bvd1_sync_q[2]) begin
        bvd_q[1] <= bvd1_sync_q[2];
      end
      if (lirq_sync_q[1] == lirq_sync_q[2]) begin
        lirq_q <= lirq_sync_q[2];
      end
    end
  end

  // Pin replacement image and ready/busy; auto-busy overrides the polled flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_repl <= 8'h00;
      host_ready_busy <= 1'b0;
      bvd_out <= 2'h0;
    end else begin
      if (ifc4_q[IFC4_POLL_BIT] && host.ata_io_mode) begin
        pin_repl[1] <= busy_q;
      end
      if (ifc4_q[IFC4_BVD_BIT]) begin
        pin_repl[3:2] <= bvd_q;
      end
      // Disabled bvd_out pins drop to zero, while pin_repl[3:2] keeps the last battery state it latched
      bvd_out <= ifc4_q[IFC4_BVD_BIT] ? bvd_q : 2'b00;
      host_ready_busy <= abusy_q
        || (ifc4_q[IFC4_POLL_BIT] && host.ata_mem_mode && busy_q);
    end
  end

  // Host event interrupt held until the enable is cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ev_q <= 1'b0;
    end else if (!ifc4_q[IFC4_HEV_BIT]) begin
      host_ev_q <= 1'b0;
    end else if (host.io_event_wr) begin
      host_ev_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_cpu_irq_pin <= 1'b0;
    end else begin
      local_cpu_irq_pin <= ifc4_q[IFC4_GIE_BIT] && (lirq_q || host_ev_q);
    end
  end

  // Auto-busy after host reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abusy_q <= 1'b0;
      abusy_cnt_q <= 16'h0000;
    end else if (host.reset_req && ifc4_q[IFC4_ABUSY_BIT]) begin
      abusy_q <= 1'b1;
      abusy_cnt_q <= 16'(ABUSY_LEN - 1);
    end else if (abusy_q) begin
      if (local_busy_clear || abusy_cnt_q == 16'h0000) begin
        abusy_q <= 1'b0;
      end else begin
        abusy_cnt_q <= abusy_cnt_q - 16'h0001;
      end
    end
  end

  // Power-management timer
  always_comb begin
    unique case (pccfg_scale_t'(ifc4_q[2:0]))
      PM_SCALE_A, PM_SCALE_C, PM_SCALE_D: tick_len = 16'(TICK_6P4_CYC);
      PM_SCALE_B: tick_len = 16'(TICK_12P8_CYC);
      PM_SCALE_FAST: tick_len = 16'(TICK_100_CYC);
      default: tick_len = 16'h0000;
    endcase
  end

  assign tick = (tick_len != 16'h0000) && (tick_cnt_q >= tick_len - 16'h0001);
  assign pm_limit = 36'(PM_BLOCK / 64) * 36'(pm_count_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 16'h0000;
      pm_cnt_q <= 36'h0;
      pm_down_q <= 1'b0;
    end else if (host.bus_activity) begin
      tick_cnt_q <= 16'h0000;
      pm_cnt_q <= 36'h0;
      pm_down_q <= 1'b0;
    end else if (tick_len != 16'h0000 && pm_count_q != 8'h00) begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      if (tick && !pm_down_q) begin
        if (pm_cnt_q + 36'h1 >= pm_limit) begin
          pm_down_q <= 1'b1;
        end else begin
          pm_cnt_q <= pm_cnt_q + 36'h1;
        end
      end
    end
  end

  assign pm_power_down = pm_down_q;

  // Sticky event status, set wins over read clear
  always_comb begin
    ev = 3'h0;
    ev[EV_HOST_IO] = host.io_event_wr;
    ev[EV_ABUSY_DONE] = abusy_q && (local_busy_clear || abusy_cnt_q == 16'h0000);
    ev[EV_PM_EXPIRE] = tick && !pm_down_q && (pm_cnt_q + 36'h1 >= pm_limit)
      && !host.bus_activity && pm_count_q != 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h0;
    end else if (rd_en && reg_addr == ADDR_IRQ_STAT) begin
      irq_stat_q <= ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read data registered at the end of the setup phase (psel high, penable low); unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (reg_addr)
        ADDR_IFC4: prdata_q <= {24'h0, ifc4_q};
        ADDR_CMP_IO: prdata_q <= {24'h0, cmp_io_q};
        ADDR_CMP_MEM: prdata_q <= {24'h0, cmp_mem_q};
        ADDR_MODE: prdata_q <= {20'h0, mode_q};
        ADDR_PM_COUNT: prdata_q <= {24'h0, pm_count_q};
        ADDR_STATUS: prdata_q <= {24'h0, pm_down_q, abusy_q, host_ev_q, lirq_q,
          bvd_q, busy_q, index_written_q};
        ADDR_IRQ_STAT: prdata_q <= {29'h0, irq_stat_q};
        ADDR_IRQ_MASK: prdata_q <= {29'h0, irq_mask_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> tb/pccfg_checker.sv
// Checker: port-level assertions for the card configuration block
`timescale 1ns/1ps
module pccfg_checker #(
  parameter int ABUSY_LEN = pccfg_pkg::ABUSY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire pccfg_pkg::pccfg_host_t host,
  input wire logic drive_busy_raw,
  input wire logic local_busy_clear,
  input wire pccfg_pkg::pccfg_modes_t modes,
  input wire logic host_ready_busy,
  input wire logic [1:0] bvd_out,
  input wire logic local_cpu_irq_pin
);
  import pccfg_pkg::*;
  logic [7:0] ifc_q, cmem_q;
  logic [5:0] idx_q;
  logic [15:0] bcnt_q;
  wire wr = psel && penable && pwrite && pstrb[0];
  // Shadow copies so the relations can be judged against what software wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifc_q <= 8'h00;
      cmem_q <= 8'h00;
      idx_q <= 6'h00;
      bcnt_q <= 16'h0000;
    end else begin
      if (wr && paddr[9:0] == ADDR_IFC4) ifc_q <= pwdata[7:0];
      if (wr && paddr[9:0] == ADDR_CMP_MEM) cmem_q <= pwdata[7:0];
      if (host.cfg_wr) idx_q <= host.cfg_index;
      bcnt_q <= host_ready_busy ? bcnt_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_busy_start: assert property (host.reset_req && ifc_q[7] |-> ##[1:3] host_ready_busy)
    else $error("auto busy did not start");
  chk_busy_len: assert property (!ifc_q[3] |-> bcnt_q <= ABUSY_LEN)
    else $error("auto busy held too long");
  chk_busy_clear: assert property (local_busy_clear && !host.reset_req && !ifc_q[3]
    |-> ##[1:3] !host_ready_busy) else $error("busy clear ignored");
  chk_irq_gate: assert property (local_cpu_irq_pin |-> ifc_q[4] || $past(ifc_q[4]))
    else $error("local interrupt without global enable");
  chk_hev_irq: assert property (host.io_event_wr && ifc_q[5:4] == 2'b11
    |-> ##[1:3] local_cpu_irq_pin) else $error("host event interrupt missing");
  chk_bvd_gate: assert property (bvd_out != 2'b00 |-> ifc_q[6] || $past(ifc_q[6]))
    else $error("battery detect shown while disabled");
  chk_poll_mem: assert property ((ifc_q[3] && host.ata_mem_mode && drive_busy_raw)[*6]
    |-> host_ready_busy) else $error("polled busy not on ready line");
  chk_mem_cmp: assert property (cmem_q[3] && modes.mem_mode_en
    |-> idx_q[2:0] == cmem_q[2:0]) else $error("memory mode without index match");
  chk_indp_cmp: assert property (cmem_q[7] && modes.indp_mode_en
    |-> idx_q[2:0] == cmem_q[6:4]) else $error("independent mode without index match");
endmodule
bind pccfg_top pccfg_checker #(.ABUSY_LEN(ABUSY_LEN)) chk (.*);

// >>> tb/pccfg_far.sv
// Far side: card host and local drive controller pins of the block
`timescale 1ns/1ps
module pccfg_far (
  input wire logic pclk,
  output pccfg_pkg::pccfg_host_t host,
  output logic drive_busy_raw,
  output logic [1:0] battery_voltage_detect,
  output logic local_irq_src,
  output logic local_busy_clear
);
  import pccfg_pkg::*;
  initial begin
    host = '0;
    drive_busy_raw = 1'b0;
    battery_voltage_detect = 2'b00;
    local_irq_src = 1'b0;
    local_busy_clear = 1'b0;
  end
  // Index goes out before any decode mode is relied upon
  task automatic cfg(input logic [5:0] i);
    @(posedge pclk);
    host.cfg_wr <= 1'b1;
    host.cfg_index <= i;
    @(posedge pclk);
    host.cfg_wr <= 1'b0;
  endtask
  // One-cycle strobes: 0 event write, 1 host reset, 2 local busy clear, 3 host bus activity
  task automatic strobe(input int k);
    @(posedge pclk);
    host.bus_activity <= (k == 3);
    host.io_event_wr <= (k == 0);
    host.reset_req <= (k == 1);
    local_busy_clear <= (k == 2);
    @(posedge pclk);
    host.bus_activity <= 1'b0;
    host.io_event_wr <= 1'b0;
    host.reset_req <= 1'b0;
    local_busy_clear <= 1'b0;
  endtask
endmodule

// >>> tb/pccfg_top_tb.sv
// Testbench: registers, compare, auto-busy, polling and interrupts of the block
`timescale 1ns/1ps
module pccfg_top_tb;
  import pccfg_pkg::*;
  localparam int ABL = 8;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'h0, strb = 4'hF;
  logic pready, pslverr, drive_busy_raw, local_irq_src, local_busy_clear;
  logic host_ready_busy, local_cpu_irq_pin, pm_power_down, irq;
  logic [1:0] battery_voltage_detect, bvd_out;
  logic [7:0] pin_repl;
  pccfg_host_t host;
  pccfg_modes_t modes;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  pccfg_top #(.ABUSY_LEN(ABL), .PM_BLOCK(640)) uut (.*);
  pccfg_far far (.*);
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, a};
    pwdata <= d;
    pstrb <= w ? strb : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs();
    apb(0, ADDR_IFC4, 0);
    chk(rd, 32'h00);
    apb(0, ADDR_CMP_IO, 0);
    chk(rd, {24'h0, RST_CMP});
    apb(1, ADDR_CMP_IO, 32'hFFFFFFB9);
    apb(0, ADDR_CMP_IO, 0);
    chk(rd, 32'hB9);
    apb(1, ADDR_CMP_MEM, 32'hAD);
    apb(0, ADDR_CMP_MEM, 0);
    chk(rd, 32'hAD);
    // Lane 0 strobe low: the byte register must keep its value
    strb = 4'hE;
    apb(1, ADDR_CMP_MEM, 32'h55);
    strb = 4'hF;
    apb(0, ADDR_CMP_MEM, 0);
    chk(rd, 32'hAD);
    // Unmapped place must swallow writes and read as zero
    apb(1, 10'h040, 32'hFFFFFFFF);
    apb(0, 10'h040, 0);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_cmp();
    apb(1, ADDR_MODE, 32'h0F43);
    for (int i = 0; i < 8; i++) begin
      far.cfg(6'(i));
      @(negedge pclk);
      chk({modes.io_mode_en, modes.mem_mode_en, modes.indp_mode_en, modes.pri_sec_en},
        {i == 3, i == 5, i == 2, {2{i == 3}}, {2{i == 1}}});
    end
    apb(1, ADDR_CMP_IO, 0);
    apb(1, ADDR_CMP_MEM, 0);
    @(negedge pclk);
    chk(modes, 7'h7F);
    $display("t_cmp done");
  endtask
  task automatic t_busy();
    int n;
    apb(1, ADDR_IFC4, 32'h80);
    far.strobe(1);
    n = 0;
    while (host_ready_busy !== 1'b1 && n < 10) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (host_ready_busy === 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    chk(n, ABL);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h2);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h0);
    far.strobe(1);
    repeat (3) @(negedge pclk);
    chk(host_ready_busy, 1);
    far.strobe(2);
    repeat (4) @(negedge pclk);
    chk(host_ready_busy, 0);
    apb(1, ADDR_IFC4, 0);
    far.strobe(1);
    n = 0;
    repeat (12) begin
      @(negedge pclk);
      if (host_ready_busy !== 1'b0) n++;
    end
    chk(n, 0);
    $display("t_busy done");
  endtask
  task automatic t_poll();
    apb(1, ADDR_IFC4, 32'h08);
    far.host.ata_mem_mode <= 1'b1;
    far.drive_busy_raw <= 1'b1;
    repeat (8) @(negedge pclk);
    chk(host_ready_busy, 1);
    @(posedge pclk);
    far.drive_busy_raw <= 1'b0;
    repeat (8) @(negedge pclk);
    chk(host_ready_busy, 0);
    @(posedge pclk);
    far.host.ata_mem_mode <= 1'b0;
    far.host.ata_io_mode <= 1'b1;
    far.drive_busy_raw <= 1'b1;
    repeat (8) @(negedge pclk);
    chk(pin_repl[1], 1);
    apb(1, ADDR_IFC4, 0);
    far.host.ata_io_mode <= 1'b0;
    far.host.ata_mem_mode <= 1'b1;
    repeat (8) @(negedge pclk);
    chk(host_ready_busy, 0);
    @(posedge pclk);
    far.host.ata_mem_mode <= 1'b0;
    far.drive_busy_raw <= 1'b0;
    $display("t_poll done");
  endtask
  task automatic t_irq();
    apb(0, ADDR_IRQ_STAT, 0);
    far.local_irq_src <= 1'b1;
    repeat (8) @(negedge pclk);
    chk(local_cpu_irq_pin, 0);
    apb(1, ADDR_IFC4, 32'h10);
    repeat (4) @(negedge pclk);
    chk(local_cpu_irq_pin, 1);
    @(posedge pclk);
    far.local_irq_src <= 1'b0;
    apb(1, ADDR_IRQ_MASK, 32'h1);
    apb(1, ADDR_IFC4, 32'h30);
    far.strobe(0);
    repeat (20) @(negedge pclk);
    chk({local_cpu_irq_pin, irq}, 2'b11);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h1);
    @(negedge pclk);
    chk(irq, 0);
    apb(1, ADDR_IRQ_MASK, 32'h0);
    far.strobe(0);
    repeat (3) @(negedge pclk);
    chk(irq, 0);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h1);
    apb(1, ADDR_IFC4, 32'h10);
    repeat (4) @(negedge pclk);
    chk(local_cpu_irq_pin, 0);
    @(posedge pclk);
    far.battery_voltage_detect <= 2'b10;
    apb(1, ADDR_IFC4, 32'h40);
    repeat (6) @(negedge pclk);
    chk({pin_repl[3:2], bvd_out}, 4'hA);
    apb(1, ADDR_IFC4, 0);
    repeat (4) @(negedge pclk);
    chk(bvd_out, 0);
    $display("t_irq done");
  endtask
  // Scale 100 ns is one cycle; interval = 1 * 640/64 * count 1 = 10 cycles
  task automatic t_pm();
    apb(1, ADDR_IFC4, 32'h04);
    repeat (10) @(negedge pclk);
    chk(pm_power_down, 0);
    @(negedge pclk);
    chk({pm_power_down, irq}, 2'b10);
    far.strobe(3);
    @(negedge pclk);
    chk(pm_power_down, 0);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h4);
    apb(1, ADDR_IFC4, 32'h02);
    repeat (20) @(negedge pclk);
    chk(pm_power_down, 0);
    $display("t_pm done");
  endtask
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cmp();
    t_busy();
    t_poll();
    t_irq();
    t_pm();
    wrap_up();
  end
endmodule
